/* kbd_input_cfg.svh */
// Constants for the keyboard input decoder.
// Assumes inclusion by its bare name from the package and design files.
`ifndef KBD_INPUT_CFG_SVH
`define KBD_INPUT_CFG_SVH

`define KBD_CODE_W        7
`define KBD_FIFO_DEPTH    32
// Space character code, shown on memory data after reset and full clear
`define KBD_SPACE_CODE    7'h20
// Memory data word at reset: space under the memory polarity
`define KBD_MEM_RESET     7'h7f
`define KBD_SYNC_STAGES   2

`endif

/* kbd_input_pkg.sv */
// Types shared by the keyboard input decoder.
// Assumes kbd_input_cfg.svh is on the include path.
`include "kbd_input_cfg.svh"

package kbd_input_pkg;

    // Function key levels, one bit per key
    typedef struct packed {
        logic clearKey;
        logic clearForegroundKey;
        logic printKey;
        logic sendPageKey;
        logic shiftAKey;
        logic shiftBKey;
        logic returnKey;
        logic insertCharKey;
        logic deleteCharKey;
        logic controlKey;
        logic repeatKey;
        logic insertLineKey;
        logic deleteLineKey;
        logic homeKey;
        logic leftKey;
        logic rightKey;
        logic upKey;
        logic downKey;
        logic tabKey;
    } keys_t;

    // Function command latches, all active high inside the block
    typedef struct packed {
        logic fullClearCmd;
        logic cmdA;
        logic printCmd;
        logic sendPageCmd;
        logic returnCmd;
        logic alnumFlag;
        logic lineAdvanceCmd;
        logic charInsertCmd;
        logic charDeleteCmd;
        logic lineInsertCmd;
        logic lineDeleteCmd;
        logic homeCmd;
        logic cursorLeftCmd;
        logic cursorRightCmd;
        logic cursorUpCmd;
        logic tabCmd;
    } cmds_t;

    // Word handed to display memory
    typedef struct packed {
        logic [`KBD_CODE_W:1] memDataBit;
        logic                 memExtraBit;
        logic                 foreground;
        logic                 foregroundN;
    } mem_word_t;

endpackage

/* terminal_keyboard_input_decoder.sv */
// Keyboard input decoder of a video display terminal, plus its character FIFO.
// Assumes keyboard pins are asynchronous and a display memory port with ready.
`timescale 1ns/1ps
`default_nettype none
`include "kbd_input_cfg.svh"

// ----------------------------------------------------------------------
// Character FIFO
// ----------------------------------------------------------------------
module kbd_char_fifo #(
    parameter int WIDTH = `KBD_CODE_W,
    parameter int DEPTH = `KBD_FIFO_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0]      count_q, count_d;
    logic             push, pop;

    assign inReady  = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (push) begin
            wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
        end
        if (pop) begin
            rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // Storage has no reset; entries are only read once written
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Keyboard input decoder
// ----------------------------------------------------------------------
module terminal_keyboard_input_decoder #(
    parameter int CODE_W     = `KBD_CODE_W,
    parameter int FIFO_DEPTH = `KBD_FIFO_DEPTH
) (
    input  wire logic                   clock,
    input  wire logic                   rstn,
    input  wire logic [CODE_W:1]        kbdCodeBit,
    input  wire logic                   charStrobe,
    input  wire kbd_input_pkg::keys_t   keyLevelsN,
    input  wire logic                   functionKeyStrobeN,
    input  wire logic                   keyboardRestoreResetN,
    output logic                        charReady,
    output logic                        memValid,
    input  wire logic                   memReady,
    output kbd_input_pkg::mem_word_t    memWord,
    output kbd_input_pkg::cmds_t        cmds,
    output logic                        lineInsertCmdN,
    output logic                        shiftLevel,
    output logic                        controlLevel,
    output logic                        returnKeyEnable,
    output logic                        repeatPermit
);
    localparam int SW = CODE_W + $bits(kbd_input_pkg::keys_t) + 3;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [SW-1:0] syncA_q, syncB_q, prev_q;
    logic [SW-1:0] rawPins;
    assign rawPins = {kbdCodeBit, ~keyLevelsN, charStrobe,
                      ~functionKeyStrobeN, ~keyboardRestoreResetN};

    // First stage feeds the second only; edges compare stage two with prev
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            syncA_q <= '0;
            syncB_q <= '0;
            prev_q  <= '0;
        end else begin
            syncA_q <= rawPins;
            syncB_q <= syncA_q;
            prev_q  <= syncB_q;
        end
    end

    logic [CODE_W:1]      code;
    kbd_input_pkg::keys_t held, heldPrev, struck;
    logic                 charHeld, charEvt, fnActive, restore;

    assign code     = syncB_q[SW-1 -: CODE_W];
    assign held     = syncB_q[3 +: $bits(kbd_input_pkg::keys_t)];
    assign heldPrev = prev_q[3 +: $bits(kbd_input_pkg::keys_t)];
    assign charHeld = syncB_q[2];
    assign charEvt  = syncB_q[2] && !prev_q[2];
    assign fnActive = syncB_q[1];
    assign restore  = syncB_q[0];
    // Strikes count only while the keyboard flags a function key
    assign struck   = fnActive ? (held & ~heldPrev) : '0;

    logic shifted;
    assign shifted = held.shiftAKey || held.shiftBKey;

    // ------------------------------------------------------------------
    // Character path through the FIFO
    // ------------------------------------------------------------------
    logic            fifoOutValid, fifoOutReady;
    logic [CODE_W:1] fifoOutData;

    kbd_char_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_DEPTH)) charFifo (
        .clock   (clock),
        .rstn    (rstn),
        .inValid (charEvt),
        .inReady (charReady),
        .inData  (code),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData (fifoOutData)
    );

    // Memory polarity: all bits inverted except bit 6
    function automatic logic [CODE_W:1] toMem(input logic [CODE_W:1] c);
        logic [CODE_W:1] m;
        m    = ~c;
        m[6] = c[6];
        return m;
    endfunction

    kbd_input_pkg::mem_word_t memWord_q, memWord_d;
    logic                     memValid_q, memValid_d;
    kbd_input_pkg::cmds_t     cmds_q, cmds_d;

    // Holding register accepts a new word once memory took the last one
    assign fifoOutReady = !memValid_q || memReady;

    always_comb begin
        memWord_d             = memWord_q;
        memValid_d            = memValid_q && !memReady;
        memWord_d.memExtraBit = 1'b1;
        memWord_d.foreground  = 1'b1;
        memWord_d.foregroundN = 1'b0;
        if (fifoOutValid && fifoOutReady) begin
            memWord_d.memDataBit = toMem(fifoOutData);
            memValid_d           = 1'b1;
        end
        // Full clear overrides a pending word so the screen fills with space
        if (struck.clearKey && shifted) begin
            memWord_d.memDataBit = toMem(`KBD_SPACE_CODE);
        end
    end

    // ------------------------------------------------------------------
    // Command latches; a set beats a character or function-key clear in the same cycle, but restore reset beats a set
    // ------------------------------------------------------------------
    logic anyStruck;
    assign anyStruck  = |struck;

    always_comb begin
        kbd_input_pkg::keys_t other;
        other             = struck;
        other.controlKey  = 1'b0;
        other.shiftAKey   = 1'b0;
        other.shiftBKey   = 1'b0;
        other.repeatKey   = 1'b0;
        cmds_d            = cmds_q;
        if (charEvt) begin
            cmds_d                = '0;
            cmds_d.alnumFlag      = 1'b1;
            cmds_d.charInsertCmd  = held.insertCharKey;
        end
        // Any function key drops the return group except control, shift A, shift B and repeat
        if (|other) begin
            cmds_d.returnCmd      = 1'b0;
            cmds_d.alnumFlag      = 1'b0;
            cmds_d.lineAdvanceCmd = 1'b0;
        end
        if (struck.clearKey && shifted)           cmds_d.fullClearCmd = 1'b1;
        if (struck.clearForegroundKey && shifted) cmds_d.cmdA = 1'b1;
        if (struck.printKey && shifted)           cmds_d.printCmd = 1'b1;
        if (struck.sendPageKey && shifted)        cmds_d.sendPageCmd = 1'b1;
        if (struck.returnKey) begin
            cmds_d.returnCmd      = 1'b1;
            cmds_d.alnumFlag      = 1'b1;
            cmds_d.lineAdvanceCmd = 1'b1;
        end
        if (struck.downKey)       cmds_d.lineAdvanceCmd = 1'b1;
        if (struck.deleteCharKey) cmds_d.charDeleteCmd = 1'b1;
        if (struck.insertLineKey) cmds_d.lineInsertCmd = 1'b1;
        if (struck.deleteLineKey) cmds_d.lineDeleteCmd = 1'b1;
        if (struck.homeKey)       cmds_d.homeCmd = 1'b1;
        if (struck.leftKey)       cmds_d.cursorLeftCmd = 1'b1;
        if (struck.rightKey)      cmds_d.cursorRightCmd = 1'b1;
        if (struck.upKey)         cmds_d.cursorUpCmd = 1'b1;
        if (struck.tabKey)        cmds_d.tabCmd = 1'b1;
        // Restore reset has the last word over every latch
        if (restore) begin
            cmds_d = '0;
        end
    end

    logic levels_q [4];
    logic [3:0] levels_d;
    always_comb begin
        levels_d[0] = shifted;
        levels_d[1] = held.controlKey;
        levels_d[2] = held.returnKey;
        levels_d[3] = held.repeatKey && (charHeld || held.leftKey
                      || held.rightKey || held.upKey || held.downKey);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            memWord_q  <= '{memDataBit: `KBD_MEM_RESET, memExtraBit: 1'b1,
                           foreground: 1'b1, foregroundN: 1'b0};
            memValid_q <= 1'b0;
            cmds_q     <= '0;
            for (int i = 0; i < 4; i++) begin
                levels_q[i] <= 1'b0;
            end
        end else begin
            memWord_q  <= memWord_d;
            memValid_q <= memValid_d;
            cmds_q     <= cmds_d;
            for (int i = 0; i < 4; i++) begin
                levels_q[i] <= levels_d[i];
            end
        end
    end

    assign memWord         = memWord_q;
    assign memValid        = memValid_q;
    assign cmds            = cmds_q;
    assign lineInsertCmdN  = !cmds_q.lineInsertCmd;
    assign shiftLevel      = levels_q[0];
    assign controlLevel    = levels_q[1];
    assign returnKeyEnable = levels_q[2];
    assign repeatPermit    = levels_q[3];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_bit6_true: assert property (@(posedge clock) disable iff (!rstn)
        (fifoOutValid && fifoOutReady && !(struck.clearKey && shifted))
        |=> memWord.memDataBit == {~$past(fifoOutData[7]), $past(fifoOutData[6]),
                                   ~$past(fifoOutData[5:1])})
        else $error("memory word polarity wrong");

    chk_clear_space: assert property (@(posedge clock) disable iff (!rstn)
        (struck.clearKey && shifted) |=> memWord.memDataBit == 7'h7f)
        else $error("full clear did not show space");

    chk_extra_fg: assert property (@(posedge clock) disable iff (!rstn)
        memWord.memExtraBit && memWord.foreground && !memWord.foregroundN)
        else $error("extra bit or foreground levels wrong");

    chk_full_clear: assert property (@(posedge clock) disable iff (!rstn)
        (struck.clearKey && !restore && (shifted || !cmds.fullClearCmd))
        |=> cmds.fullClearCmd == $past(shifted))
        else $error("full clear latch wrong after clear key");

    chk_print_shift: assert property (@(posedge clock) disable iff (!rstn)
        (struck.printKey && !shifted && !cmds.printCmd) |=> !cmds.printCmd)
        else $error("unshifted print set latch");

    chk_shift_level: assert property (@(posedge clock) disable iff (!rstn)
        ##1 shiftLevel == $past(shifted))
        else $error("shift level wrong");

    chk_char_clears: assert property (@(posedge clock) disable iff (!rstn)
        (charEvt && !anyStruck && !restore) |=> !cmds.homeCmd && !cmds.tabCmd
            && lineInsertCmdN && cmds.alnumFlag)
        else $error("character did not clear commands");

    chk_repeat_alone: assert property (@(posedge clock) disable iff (!rstn)
        (held.repeatKey && !charHeld && !held.leftKey && !held.rightKey
         && !held.upKey && !held.downKey) |=> !repeatPermit)
        else $error("repeat permit without a key");

    chk_restore_clr: assert property (@(posedge clock) disable iff (!rstn)
        restore |=> (cmds == '0) && lineInsertCmdN)
        else $error("restore reset left a latch set");

    chk_ctrl_alnum: assert property (@(posedge clock) disable iff (!rstn)
        (cmds.alnumFlag && struck == kbd_input_pkg::keys_t'(19'h00200)
         && !charEvt && !restore) |=> cmds.alnumFlag)
        else $error("control key cleared alnum flag");

endmodule
`default_nettype wire

/* kbd_keyboard_model.sv */
// Keyboard switch encoder and display memory port seen from the decoder.
// Assumes the bench sets key and character levels just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Keyboard and memory model
// ----------------------------------------------------------------------
module kbd_keyboard_model (
    input  wire logic                      clock,
    input  wire logic                      rstn,
    input  wire kbd_input_pkg::keys_t      held,
    input  wire logic                      charHeld,
    input  wire logic [7:1]                code,
    input  wire logic                      slow,
    input  wire logic                      stall,
    output kbd_input_pkg::keys_t           keyLevelsN,
    output logic                           functionKeyStrobeN,
    output logic [7:1]                     kbdCodeBit,
    output logic                           charStrobe,
    input  wire logic                      memValid,
    output logic                           memReady,
    input  wire kbd_input_pkg::mem_word_t  memWord
);
    kbd_input_pkg::mem_word_t got[$];
    logic                     phase_q;

    // Key contacts pull low while held
    assign keyLevelsN = ~held;
    assign functionKeyStrobeN = ~|held;
    // Code lines sit low with no key down, true polarity otherwise
    assign kbdCodeBit = charHeld ? code : 7'h00;
    assign charStrobe = charHeld;

    // Slow memory accepts only every other cycle, to stall the holding register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end
    assign memReady = !stall && (!slow || phase_q);

    always @(posedge clock) begin
        if (rstn && memValid && memReady) begin
            got.push_back(memWord);
        end
    end
endmodule
`default_nettype wire

/* terminal_keyboard_input_decoder_test.sv */
// Self-checking bench for the keyboard input decoder.
// Assumes the design package, header and the keyboard model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module terminal_keyboard_input_decoder_test;
    localparam int DEPTH    = 32;
    localparam int SK[9]    = '{10, 7, 6, 5, 4, 3, 2, 0, 1};
    localparam int SC[9]    = '{7, 6, 5, 4, 3, 2, 1, 0, 9};
    localparam int FK[4]    = '{18, 17, 16, 15};
    localparam int FC[4]    = '{15, 14, 13, 12};
    localparam int ARROW[4] = '{4, 3, 2, 1};
    logic                      clock;
    logic                      rstn;
    logic                      restoreN;
    logic                      charHeld;
    logic                      slow;
    logic                      stall;
    logic [7:1]                code;
    logic [7:1]                kbdCodeBit;
    logic                      charStrobe;
    logic                      functionKeyStrobeN;
    logic                      charReady;
    logic                      memValid;
    logic                      memReady;
    logic                      lineInsertCmdN;
    logic                      shiftLevel;
    logic                      controlLevel;
    logic                      returnKeyEnable;
    logic                      repeatPermit;
    kbd_input_pkg::keys_t      held;
    kbd_input_pkg::keys_t      keyLevelsN;
    kbd_input_pkg::mem_word_t  memWord;
    kbd_input_pkg::cmds_t      cmds;
    int                        failures;
    int                        compares;
    int                        accepted;

    kbd_keyboard_model i_keyboard (.clock(clock), .rstn(rstn), .held(held),
        .charHeld(charHeld), .code(code), .slow(slow), .stall(stall),
        .keyLevelsN(keyLevelsN), .functionKeyStrobeN(functionKeyStrobeN),
        .kbdCodeBit(kbdCodeBit), .charStrobe(charStrobe), .memValid(memValid),
        .memReady(memReady), .memWord(memWord));

    terminal_keyboard_input_decoder i_terminal_keyboard_input_decoder (.clock(clock),
        .rstn(rstn), .kbdCodeBit(kbdCodeBit), .charStrobe(charStrobe),
        .keyLevelsN(keyLevelsN), .functionKeyStrobeN(functionKeyStrobeN),
        .keyboardRestoreResetN(restoreN), .charReady(charReady), .memValid(memValid),
        .memReady(memReady), .memWord(memWord), .cmds(cmds),
        .lineInsertCmdN(lineInsertCmdN), .shiftLevel(shiftLevel),
        .controlLevel(controlLevel), .returnKeyEnable(returnKeyEnable),
        .repeatPermit(repeatPermit));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    initial clock = 1'b0;
    always #4 clock = ~clock;

    task automatic close_out();
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Inputs move 1 ns after the edge so no race with the design's sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        compares++;
        if (got !== want) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask

    // Five cycles per level covers the two sync stages plus the register
    task automatic hold(input int b);
        held[b] = 1'b1;
        tick(5);
    endtask

    task automatic drop(input int b);
        held[b] = 1'b0;
        tick(5);
    endtask

    task automatic key(input logic [7:1] c);
        code = c;
        charHeld = 1'b1;
        tick(5);
        charHeld = 1'b0;
        tick(5);
    endtask

    function automatic kbd_input_pkg::cmds_t onehot(input int b);
        kbd_input_pkg::cmds_t f;
        f = '0;
        f[b] = 1'b1;
        return f;
    endfunction

    function automatic kbd_input_pkg::mem_word_t memExp(input logic [7:1] c);
        kbd_input_pkg::mem_word_t m;
        m = '0;
        m.memDataBit = ~c;
        m.memDataBit[6] = c[6];
        m.memExtraBit = 1'b1;
        m.foreground = 1'b1;
        return m;
    endfunction

    task automatic memChk(input logic [7:1] c);
        if (i_keyboard.got.size() == 0) begin
            chk(16'h0001, 16'h0000);
        end else begin
            chk(i_keyboard.got.pop_front(), memExp(c));
        end
    endtask

    initial begin
        #200000;
        failures++;
        close_out();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        failures = 0;
        compares = 0;
        rstn = 1'b0;
        restoreN = 1'b1;
        held = '0;
        charHeld = 1'b0;
        code = 7'h00;
        slow = 1'b0;
        stall = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(2);
        chk(memWord, memExp(7'h20));
        chk(cmds, '0);
        chk(lineInsertCmdN, 1'b1);
        foreach (FK[i]) begin
            key(7'h5f);
            memChk(7'h5f);
            hold(FK[i]);
            drop(FK[i]);
            chk(cmds[FC[i]], 1'b0);
            hold(14);
            hold(FK[i]);
            drop(FK[i]);
            drop(14);
            chk(cmds, onehot(FC[i]));
            if (i == 0) begin
                chk(memWord.memDataBit, 7'h7f);
            end
            key(7'h41);
            memChk(7'h41);
            chk(cmds, onehot(10));
        end
        foreach (SK[i]) begin
            hold(SK[i]);
            drop(SK[i]);
            chk(cmds, onehot(SC[i]));
            chk(lineInsertCmdN, (i == 1) ? 1'b0 : 1'b1);
            key(7'h3f);
            memChk(7'h3f);
            chk(cmds, onehot(10));
        end
        hold(12);
        chk(returnKeyEnable, 1'b1);
        drop(12);
        chk(returnKeyEnable, 1'b0);
        chk(cmds, onehot(11) | onehot(10) | onehot(9));
        hold(5);
        drop(5);
        chk(cmds, onehot(4));
        hold(11);
        chk(cmds.charInsertCmd, 1'b0);
        key(7'h32);
        memChk(7'h32);
        chk(cmds, onehot(8) | onehot(10));
        drop(11);
        key(7'h33);
        memChk(7'h33);
        chk(cmds, onehot(10));
        hold(9);
        chk(controlLevel, 1'b1);
        chk(cmds.alnumFlag, 1'b1);
        drop(9);
        chk(controlLevel, 1'b0);
        hold(14);
        chk(shiftLevel, 1'b1);
        hold(13);
        drop(14);
        chk(shiftLevel, 1'b1);
        drop(13);
        chk(shiftLevel, 1'b0);
        hold(8);
        chk(repeatPermit, 1'b0);
        code = 7'h34;
        charHeld = 1'b1;
        tick(5);
        chk(repeatPermit, 1'b1);
        charHeld = 1'b0;
        tick(5);
        memChk(7'h34);
        foreach (ARROW[a]) begin
            hold(ARROW[a]);
            chk(repeatPermit, 1'b1);
            drop(ARROW[a]);
        end
        drop(8);
        hold(4);
        chk(repeatPermit, 1'b0);
        drop(4);
        code = 7'h35;
        charHeld = 1'b1;
        tick(5);
        chk(repeatPermit, 1'b0);
        charHeld = 1'b0;
        tick(5);
        memChk(7'h35);
        hold(5);
        drop(5);
        restoreN = 1'b0;
        tick(4);
        chk(cmds, '0);
        restoreN = 1'b1;
        tick(3);
        // Stalled memory: holding register plus the full FIFO, then refusal
        stall = 1'b1;
        accepted = 0;
        for (int i = 0; i < 40; i++) begin
            if (charReady === 1'b1) begin
                accepted++;
            end
            key(7'(i) ^ 7'h40);
        end
        chk(16'(accepted), 16'(DEPTH + 1));
        chk(charReady, 1'b0);
        chk(memValid, 1'b1);
        slow = 1'b1;
        stall = 1'b0;
        tick(400);
        chk(16'(i_keyboard.got.size()), 16'(accepted));
        for (int j = 0; j < accepted; j++) begin
            memChk(7'(j) ^ 7'h40);
        end
        chk(charReady, 1'b1);
        chk(memValid, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
